/* File: rtl/asx_alu.sv */
/*
 * Execution datapath for five single-word instructions: subtract with
 * borrow, nibble swap, XOR literal, XOR file, and direction load.
 * Assumes the decoder presents one instruction per cycle with the
 * addressed file register already read on file_rdata, all on clk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "asx_params.svh"

module asx_alu #(
    parameter int DATA_W = `ASX_DATA_W,
    parameter int ADDR_W = `ASX_ADDR_W
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             ce,
    input  wire logic             op_valid,
    input  wire asx_pkg::asx_op_t op_code,
    input  wire logic [6:0]       file_addr,
    input  wire logic             dest_bit,
    input  wire logic [7:0]       literal,
    input  wire logic [7:0]       file_rdata,
    output logic      [7:0]       w_out,
    output logic                  carry_flag,
    output logic                  digit_carry_flag,
    output logic                  zero_flag,
    output logic      [7:0]       port_a_direction,
    output logic      [7:0]       port_b_direction,
    output logic      [7:0]       port_c_direction,
    output logic                  file_we,
    output logic      [6:0]       file_waddr,
    output logic      [7:0]       file_wdata,
    output logic                  done
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // The flag and nibble logic is written for a byte-wide core only
    if (DATA_W != `ASX_DATA_W || ADDR_W != `ASX_ADDR_W) begin : g_bad_width
        $error("asx_alu supports only 8-bit data and 7-bit file addresses");
    end

    // ************************************************************
    // State
    // ************************************************************
    asx_pkg::asx_state_t st_r;
    asx_pkg::asx_state_t st_nxt;

    always_comb begin
        logic [8:0] diff;
        logic [4:0] ndiff;
        logic [7:0] res;
        logic       to_file;
        diff    = 9'h000;
        ndiff   = 5'h00;
        res     = `ASX_BYTE_ZERO;
        to_file = 1'b0;
        st_nxt  = st_r;
        st_nxt.file_we = 1'b0;
        st_nxt.done    = 1'b0;
        if (op_valid) begin
            st_nxt.done = 1'b1;
            case (op_code)
                asx_pkg::ASX_OP_SUBB: begin
                    // Adding ~W plus carry gives f - W - !carry
                    diff  = {1'b0, file_rdata} + {1'b0, ~st_r.w} + {8'h00, st_r.carry};
                    ndiff = {1'b0, file_rdata[`ASX_NIB_LO]} + {1'b0, ~st_r.w[`ASX_NIB_LO]}
                          + {4'h0, st_r.carry};
                    res   = diff[`ASX_BYTE_BITS];
                    st_nxt.carry            = diff[`ASX_CARRY_BIT];
                    st_nxt.digit_carry_flag = ndiff[`ASX_DC_BIT];
                    st_nxt.zero             = (res == `ASX_BYTE_ZERO);
                    to_file = (dest_bit != `ASX_DEST_W);
                end
                asx_pkg::ASX_OP_SWAP: begin
                    res = {file_rdata[`ASX_NIB_LO], file_rdata[`ASX_NIB_HI]};
                    to_file = (dest_bit != `ASX_DEST_W);
                end
                asx_pkg::ASX_OP_XORL: begin
                    res = st_r.w ^ literal;
                    st_nxt.zero = (res == `ASX_BYTE_ZERO);
                    to_file = 1'b0;
                end
                asx_pkg::ASX_OP_XORF: begin
                    res = st_r.w ^ file_rdata;
                    st_nxt.zero = (res == `ASX_BYTE_ZERO);
                    to_file = (dest_bit != `ASX_DEST_W);
                end
                asx_pkg::ASX_OP_DIRL: begin
                    res = st_r.w;
                    // Selectors outside 5..7 are ignored rather than aliased
                    if (file_addr[`ASX_SEL_UPPER] == `ASX_SEL_UP_ZERO) begin
                        case (file_addr[`ASX_SEL_BITS])
                            `ASX_SEL_PORT_A: st_nxt.port_a_direction = st_r.w;
                            `ASX_SEL_PORT_B: st_nxt.port_b_direction = st_r.w;
                            `ASX_SEL_PORT_C: st_nxt.port_c_direction = st_r.w;
                            default: st_nxt.done = 1'b1;
                        endcase
                    end
                end
                default: st_nxt.done = 1'b0;
            endcase
            if (op_code != asx_pkg::ASX_OP_DIRL && op_code <= asx_pkg::ASX_OP_XORF) begin
                if (to_file) begin
                    st_nxt.file_we    = 1'b1;
                    st_nxt.file_waddr = file_addr;
                    st_nxt.file_wdata = res;
                end else begin
                    st_nxt.w = res;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '{w: `ASX_W_RST, carry: 1'b0, digit_carry_flag: 1'b0, zero: 1'b0,
                      port_a_direction: `ASX_DIR_RST, port_b_direction: `ASX_DIR_RST,
                      port_c_direction: `ASX_DIR_RST, file_we: 1'b0,
                      file_waddr: `ASX_ADDR_ZERO, file_wdata: `ASX_BYTE_ZERO, done: 1'b0};
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign w_out            = st_r.w;
    assign carry_flag       = st_r.carry;
    assign digit_carry_flag = st_r.digit_carry_flag;
    assign zero_flag        = st_r.zero;
    assign port_a_direction = st_r.port_a_direction;
    assign port_b_direction = st_r.port_b_direction;
    assign port_c_direction = st_r.port_c_direction;
    assign file_we          = st_r.file_we;
    assign file_waddr       = st_r.file_waddr;
    assign file_wdata       = st_r.file_wdata;
    assign done             = st_r.done;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic go;
    assign go = ce && op_valid;

    chk_sub_value : assert property (
        go && op_code == asx_pkg::ASX_OP_SUBB && !dest_bit |=>
        w_out == 8'($past(file_rdata) - $past(w_out) - 8'(!$past(carry_flag))))
        else $error("subtract with borrow result wrong");

    chk_sub_flags : assert property (
        go && op_code == asx_pkg::ASX_OP_SUBB |=>
        carry_flag == ($past(file_rdata) + 9'h000 >= $past(w_out) + 9'(!$past(carry_flag)))
        && $stable(port_a_direction))
        else $error("subtract with borrow flags wrong");

    chk_dest_file : assert property (
        go && dest_bit && (op_code == asx_pkg::ASX_OP_SWAP || op_code == asx_pkg::ASX_OP_XORF)
        |=> file_we && file_waddr == $past(file_addr) && $stable(w_out)
        ##1 (!file_we || !$past(ce) || $past(op_valid)))
        else $error("destination file write wrong");

    chk_swap_flags : assert property (
        go && op_code == asx_pkg::ASX_OP_SWAP && !dest_bit |=>
        w_out == {$past(file_rdata[`ASX_NIB_LO]), $past(file_rdata[`ASX_NIB_HI])}
        && $stable(zero_flag) && $stable(carry_flag) && $stable(digit_carry_flag))
        else $error("nibble swap wrong");

    chk_xorl_w : assert property (
        go && op_code == asx_pkg::ASX_OP_XORL |=>
        w_out == ($past(w_out) ^ $past(literal)) && !file_we && $stable(carry_flag))
        else $error("xor literal wrong");

    chk_xorf_zero : assert property (
        go && op_code == asx_pkg::ASX_OP_XORF |=>
        zero_flag == ($past(w_out) == $past(file_rdata)) && $stable(digit_carry_flag))
        else $error("xor file zero flag wrong");

    chk_dir_load : assert property (
        go && op_code == asx_pkg::ASX_OP_DIRL
        && file_addr == {`ASX_SEL_UP_ZERO, `ASX_SEL_PORT_B} |=>
        port_b_direction == $past(w_out) && $stable(port_a_direction)
        && $stable(port_c_direction) && $stable(zero_flag))
        else $error("direction load wrong");

    chk_zero_def : assert property (
        go && op_code == asx_pkg::ASX_OP_XORL && !dest_bit |=>
        zero_flag == (w_out == 8'h00))
        else $error("zero flag disagrees with result");

    // A write-back subtract must leave W alone and carry the borrowed result
    chk_sub_file : assert property (
        go && op_code == asx_pkg::ASX_OP_SUBB && dest_bit |=>
        file_we && file_waddr == $past(file_addr) && $stable(w_out)
        && file_wdata == 8'($past(file_rdata) - $past(w_out) - 8'(!$past(carry_flag))))
        else $error("subtract with borrow write back wrong");

    chk_dir_ignore : assert property (
        go && op_code == asx_pkg::ASX_OP_DIRL
        && (file_addr[`ASX_SEL_UPPER] != `ASX_SEL_UP_ZERO
            || file_addr[`ASX_SEL_BITS] < `ASX_SEL_PORT_A) |=>
        done && $stable(port_a_direction) && $stable(port_b_direction)
        && $stable(port_c_direction) && $stable(w_out))
        else $error("stray direction selector changed state");

    // Codes above the direction load are reserved and must do nothing at all
    chk_unknown_op : assert property (
        go && op_code > asx_pkg::ASX_OP_DIRL |=>
        !done && !file_we && $stable(w_out) && $stable(zero_flag) && $stable(carry_flag))
        else $error("reserved operation code had an effect");

    // A stalled core keeps every pulse standing so nothing is lost
    chk_stall_hold : assert property (
        !ce |=> $stable(done) && $stable(file_we) && $stable(w_out) && $stable(zero_flag))
        else $error("state moved while the clock enable was low");

    cov_sub_borrow  : cover property (go && op_code == asx_pkg::ASX_OP_SUBB && !carry_flag);
    cov_file_write  : cover property (file_we);
    cov_dir_c       : cover property (go && op_code == asx_pkg::ASX_OP_DIRL
                                      && file_addr == {`ASX_SEL_UP_ZERO, `ASX_SEL_PORT_C});
    cov_stall_pulse : cover property (done && !ce);
    cov_dir_stray   : cover property (go && op_code == asx_pkg::ASX_OP_DIRL
                                      && file_addr[`ASX_SEL_UPPER] != `ASX_SEL_UP_ZERO);

endmodule : asx_alu
`default_nettype wire

/* File: rtl/asx_params.svh */
/*
 * Named constants for the subtract/swap/xor/direction-load datapath.
 * Assumes it is included by bare name after the package is compiled.
 */
`ifndef ASX_PARAMS_SVH
`define ASX_PARAMS_SVH

// ************************************************************
// Widths and field positions
// ************************************************************
`define ASX_DATA_W      8
`define ASX_ADDR_W      7
`define ASX_NIB_HI      7:4
`define ASX_NIB_LO      3:0
`define ASX_SEL_BITS    2:0
`define ASX_SEL_UPPER   6:3
`define ASX_BYTE_BITS   7:0
`define ASX_CARRY_BIT   8
`define ASX_DC_BIT      4

// ************************************************************
// Direction register selectors and reset values
// ************************************************************
`define ASX_SEL_PORT_A  3'h5
`define ASX_SEL_PORT_B  3'h6
`define ASX_SEL_PORT_C  3'h7
`define ASX_SEL_UP_ZERO 4'h0
`define ASX_DEST_W      1'b0
`define ASX_DIR_RST     8'hFF
`define ASX_W_RST       8'h00
`define ASX_BYTE_ZERO   8'h00
`define ASX_ADDR_ZERO   7'h00

`endif

/* File: rtl/asx_pkg.sv */
/*
 * Types shared by the datapath: operation codes and the state record.
 * Assumes the decoder drives operation codes of this type.
 */
package asx_pkg;

    typedef enum logic [2:0] {
        ASX_OP_SUBB = 3'h0,
        ASX_OP_SWAP = 3'h1,
        ASX_OP_XORL = 3'h2,
        ASX_OP_XORF = 3'h3,
        ASX_OP_DIRL = 3'h4
    } asx_op_t;

    typedef struct packed {
        logic [7:0] w;
        logic       carry;
        logic       digit_carry_flag;
        logic       zero;
        logic [7:0] port_a_direction;
        logic [7:0] port_b_direction;
        logic [7:0] port_c_direction;
        logic       file_we;
        logic [6:0] file_waddr;
        logic [7:0] file_wdata;
        logic       done;
    } asx_state_t;

endpackage : asx_pkg

/* File: tb/asx_alu_tb.sv */
/* Self-checking bench for asx_alu with the file register partner.
   Assumes the partner model compiles first and the package is present. */
`timescale 1ns/100ps
`default_nettype none
module asx_alu_tb;
    logic             clk = 1'b0, srst = 1'b1, ce = 1'b1, op_valid = 1'b0, dest_bit = 1'b0;
    asx_pkg::asx_op_t op_code = asx_pkg::ASX_OP_SUBB;
    logic [6:0]       file_addr = 7'h00, file_waddr;
    logic [7:0]       literal = 8'h00, file_rdata, w_out, file_wdata, pa, pb, pc;
    logic             carry_flag, digit_carry_flag, zero_flag, file_we, done;
    int               miscompares = 0, n_tests = 0;
    logic [7:0]       em [128];
    logic [7:0]       ew = 8'h00;
    logic [7:0]       edir [3] = '{8'hFF, 8'hFF, 8'hFF};
    logic             ec = 1'b0, edc = 1'b0, ez = 1'b0;
    always #2.5 clk = ~clk;
    asx_alu asx_alu_i (.clk(clk), .srst(srst), .ce(ce), .op_valid(op_valid), .op_code(op_code),
        .file_addr(file_addr), .dest_bit(dest_bit), .literal(literal), .file_rdata(file_rdata),
        .w_out(w_out), .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
        .zero_flag(zero_flag), .port_a_direction(pa), .port_b_direction(pb),
        .port_c_direction(pc), .file_we(file_we), .file_waddr(file_waddr),
        .file_wdata(file_wdata), .done(done));
    asx_regfile asx_regfile_i (.clk(clk), .addr(file_addr), .rdata(file_rdata), .we(file_we),
        .waddr(file_waddr), .wdata(file_wdata));
    // ****************************************
    // Checking and execution
    // ****************************************
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            miscompares++;
        end
        n_tests++;
    endtask : cmp
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    // Reference model steps first, then the instruction is issued and judged
    task automatic exe(input logic [2:0] op, input logic [6:0] a, input logic d,
                       input logic [7:0] k, input logic en);
        logic [8:0] s;
        logic [4:0] t;
        logic [7:0] f;
        logic [7:0] r;
        logic       wr;
        f = em[a];
        r = 8'h00;
        wr = en && d && (op == 3'h0 || op == 3'h1 || op == 3'h3);
        if (en) begin
            case (op)
                3'h0: begin
                    s = {1'b0, f} + {1'b0, ~ew} + {8'h00, ec};
                    t = {1'b0, f[3:0]} + {1'b0, ~ew[3:0]} + {4'h0, ec};
                    r = s[7:0];
                    ec = s[8];
                    edc = t[4];
                end
                3'h1: r = {f[3:0], f[7:4]};
                3'h2: r = ew ^ k;
                3'h3: r = ew ^ f;
                3'h4: if (a >= 7'h05 && a <= 7'h07) edir[a - 7'h05] = ew;
                default: ;
            endcase
            if (op == 3'h0 || op == 3'h2 || op == 3'h3) ez = (r == 8'h00);
            if (wr) em[a] = r;
            else if (op <= 3'h3) ew = r;
        end
        @(posedge clk);
        ce <= en;
        op_valid <= 1'b1;
        op_code <= asx_pkg::asx_op_t'(op);
        file_addr <= a;
        dest_bit <= d;
        literal <= k;
        @(posedge clk);
        op_valid <= 1'b0;
        ce <= 1'b1;
        #1;
        cmp("w", ew, w_out);
        cmp("c", {7'h00, ec}, {7'h00, carry_flag});
        cmp("dc", {7'h00, edc}, {7'h00, digit_carry_flag});
        cmp("z", {7'h00, ez}, {7'h00, zero_flag});
        cmp("dira", edir[0], pa);
        cmp("dirb", edir[1], pb);
        cmp("dirc", edir[2], pc);
        cmp("done", {7'h00, en && op <= 3'h4}, {7'h00, done});
        cmp("we", {7'h00, wr}, {7'h00, file_we});
        if (wr) begin
            cmp("waddr", {1'b0, a}, {1'b0, file_waddr});
            cmp("wdata", r, file_wdata);
        end
    endtask : exe
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_subb();
        exe(3'h2, 7'h00, 1'b0, 8'h20, 1'b1);
        exe(3'h0, 7'h00, 1'b1, 8'h00, 1'b1);
        exe(3'h2, 7'h00, 1'b0, ew, 1'b1);
        exe(3'h0, 7'h7F, 1'b0, 8'h00, 1'b1);
        exe(3'h0, 7'h00, 1'b0, 8'h00, 1'b1);
        exe(3'h0, 7'h01, 1'b0, 8'h00, 1'b1);
        $display("test subb finished");
    endtask : t_subb
    task automatic t_swap_xor();
        exe(3'h1, 7'h07, 1'b0, 8'h00, 1'b1);
        exe(3'h1, 7'h08, 1'b1, 8'h00, 1'b1);
        exe(3'h2, 7'h00, 1'b0, 8'hA5, 1'b1);
        exe(3'h3, 7'h09, 1'b1, 8'h00, 1'b1);
        exe(3'h3, 7'h09, 1'b0, 8'h00, 1'b1);
        exe(3'h2, 7'h00, 1'b0, ew, 1'b1);
        $display("test swap and xor finished");
    endtask : t_swap_xor
    task automatic t_dir();
        // Selectors outside 5..7, including upper address bits set, must change nothing
        for (int i = 4; i <= 8; i++) begin
            exe(3'h2, 7'h00, 1'b0, 8'(i * 29), 1'b1);
            exe(3'h4, 7'(i), 1'b0, 8'h00, 1'b1);
        end
        $display("test direction load finished");
    endtask : t_dir
    task automatic t_freeze();
        logic [7:0] r;
        // A stall right after an XOR write-back must keep the pulses up
        r = ew ^ em[10];
        em[10] = r;
        ez = (r == 8'h00);
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= asx_pkg::ASX_OP_XORF;
        file_addr <= 7'h0A;
        dest_bit <= 1'b1;
        @(posedge clk);
        op_valid <= 1'b0;
        ce <= 1'b0;
        @(posedge clk);
        ce <= 1'b1;
        #1;
        cmp("we held", 8'h01, {7'h00, file_we});
        cmp("done held", 8'h01, {7'h00, done});
        cmp("waddr held", 8'h0A, {1'b0, file_waddr});
        cmp("wdata held", r, file_wdata);
        cmp("z held", {7'h00, ez}, {7'h00, zero_flag});
        cmp("w held", ew, w_out);
        @(posedge clk);
        #1;
        cmp("we after", 8'h00, {7'h00, file_we});
        cmp("done after", 8'h00, {7'h00, done});
        $display("test freeze finished");
    endtask : t_freeze
    task automatic t_refuse();
        for (int i = 5; i <= 7; i++) exe(3'(i), 7'h02, 1'b1, 8'h11, 1'b1);
        exe(3'h0, 7'h03, 1'b1, 8'h00, 1'b0);
        exe(3'h2, 7'h00, 1'b0, 8'h3C, 1'b0);
        $display("test refusals finished");
    endtask : t_refuse
    initial begin
        for (int i = 0; i < 128; i++) em[i] = 8'(i * 37 + 3);
        em[0] = 8'hFF;
        em[127] = 8'h00;
        for (int i = 0; i < 128; i++) asx_regfile_i.mem[i] = em[i];
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        exe(3'h0, 7'h00, 1'b0, 8'h00, 1'b0);
        t_subb();
        t_swap_xor();
        t_dir();
        t_freeze();
        t_refuse();
        final_report();
    end
    initial begin
        #20000;
        miscompares++;
        final_report();
    end
endmodule : asx_alu_tb
`default_nettype wire

/* File: tb/asx_regfile.sv */
/* Partner model: the file register array behind the datapath.
   Assumes reads are combinational and writes land on clk. */
`timescale 1ns/100ps
`default_nettype none
module asx_regfile (
    input  wire logic       clk,
    input  wire logic [6:0] addr,
    output logic      [7:0] rdata,
    input  wire logic       we,
    input  wire logic [6:0] waddr,
    input  wire logic [7:0] wdata
);
    logic [7:0] mem [128];
    // No write forwarding, as in the core: a write lands one edge late
    assign rdata = mem[addr];
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end
endmodule : asx_regfile
`default_nettype wire
